/* card_edge_status.sv */
// Card-edge buttons, bypass state, status indicators and Wishbone registers.
// Assumes status inputs and buttons are synchronous to mclk.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module card_edge_status
    import card_edge_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq,
    // Buttons, high while pressed
    input wire logic bypass_button,
    input wire logic reset_button,
    // Status from the rest of the card
    input wire logic input_valid,
    input wire logic signal_fault,
    input wire logic stream_ser_lock,
    input wire logic display_ser_lock,
    input wire logic module_unsupported,
    input wire logic module_unknown,
    // Relay and reboot
    output logic bypass_relay,
    output logic card_reboot,
    // Indicators
    output logic [1:0] power_state_led,
    output logic bypass_red_led,
    output logic input_present_led,
    output logic stream_out_lock_led,
    output logic display_out_lock_led,
    output logic [1:0] module_support_led,
    output logic [1:0] bypass_mirror_led,
    output logic [1:0] no_input_led,
    output logic [1:0] module_unknown_led
);
    logic bypass_press;
    logic reset_press;
    logic flash_phase;
    logic bypassed;
    logic [3:0] ctrl;
    logic [ev_width-1:0] irq_status;
    logic [ev_width-1:0] irq_mask;
    logic [ev_width-1:0] events;
    logic prev_input;
    logic prev_module;
    logic [4:0] reboot_count;
    logic bus_req;
    logic bus_wr;
    logic bus_rd_status;
    led_color_t next_power;

    button_debounce u_bypass_button (
        .mclk(mclk),
        .rstn(rstn),
        .raw(bypass_button),
        .level(),
        .press(bypass_press)
    );

    button_debounce u_reset_button (
        .mclk(mclk),
        .rstn(rstn),
        .raw(reset_button),
        .level(),
        .press(reset_press)
    );

    flash_divider u_flash (
        .mclk(mclk),
        .rstn(rstn),
        .phase(flash_phase)
    );

    // Latching pushbutton: reset leaves the card in path
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            bypassed <= 1'b0;
        else if (bypass_press)
            bypassed <= ~bypassed;
    end

    // Reboot pulse stretched so the card reset sees it
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            reboot_count <= 5'h00;
        else if (reset_press || (bus_wr && adr_i == ctrl_addr && sel_i[0]
                 && dat_i[ctrl_reboot_bit]))
            reboot_count <= 5'(reboot_cycles);
        else if (reboot_count != 5'h00)
            reboot_count <= reboot_count - 5'h01;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            card_reboot <= 1'b0;
        else
            card_reboot <= (reboot_count != 5'h00);
    end

    // Bus access: one wait state, ack dropped after each answer
    assign bus_req = cyc_i && stb_i && !ack_o;
    assign bus_wr = bus_req && we_i;
    assign bus_rd_status = bus_req && !we_i && adr_i == irq_status_addr;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ack_o <= 1'b0;
        else
            ack_o <= bus_req;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= ctrl_reset;
            irq_mask <= mask_reset;
        end
        else if (bus_wr && sel_i[0])
        begin
            if (adr_i == ctrl_addr)
                ctrl <= {1'b0, dat_i[2:0]};
            else if (adr_i == irq_mask_addr)
                irq_mask <= dat_i[ev_width-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            dat_o <= 32'h00000000;
        else if (bus_req && !we_i)
        begin
            unique case (adr_i)
                ctrl_addr: dat_o <= {28'h0000000, ctrl};
                status_addr: dat_o <= {24'h000000, module_unknown, module_unsupported,
                                       display_ser_lock, stream_ser_lock, signal_fault,
                                       input_valid, reset_button, bypassed};
                irq_status_addr: dat_o <= {28'h0000000, irq_status};
                irq_mask_addr: dat_o <= {28'h0000000, irq_mask};
                default: dat_o <= 32'h00000000;
            endcase
        end
    end

    // Change events: bypass, input, reset press, module status
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_input <= 1'b0;
            prev_module <= 1'b0;
        end
        else
        begin
            prev_input <= input_valid;
            prev_module <= module_unsupported | module_unknown;
        end
    end

    always_comb
    begin
        events = '0;
        events[ev_bypass] = bypass_press;
        events[ev_input] = input_valid ^ prev_input;
        events[ev_reset_button] = reset_press;
        events[ev_module] = (module_unsupported | module_unknown) ^ prev_module;
    end

    // Read clears, but a new event in the same cycle survives
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            irq_status <= '0;
        else if (bus_rd_status)
            irq_status <= events;
        else
            irq_status <= irq_status | events;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask);
    end

    // Power state priority: boot wait, no input or not running, fault, running
    always_comb
    begin
        if (ctrl[ctrl_boot_wait_bit])
            next_power = flash_phase ? led_green : led_off;
        else if (!input_valid || !ctrl[ctrl_running_bit])
            next_power = led_red;
        else if (signal_fault || ctrl[ctrl_config_err_bit])
            next_power = led_orange;
        else
            next_power = led_green;
    end

    // Every indicator registered in one process so mirrors track exactly
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            power_state_led <= led_off;
            bypass_relay <= 1'b0;
            bypass_red_led <= 1'b0;
            input_present_led <= 1'b0;
            stream_out_lock_led <= 1'b0;
            display_out_lock_led <= 1'b0;
            module_support_led <= led_green;
            bypass_mirror_led <= led_green;
            no_input_led <= led_red;
            module_unknown_led <= led_green;
        end
        else
        begin
            power_state_led <= next_power;
            bypass_relay <= bypassed;
            bypass_red_led <= bypassed;
            bypass_mirror_led <= bypassed ? led_red : led_green;
            input_present_led <= input_valid;
            no_input_led <= input_valid ? led_green : led_red;
            stream_out_lock_led <= stream_ser_lock && input_valid;
            display_out_lock_led <= display_ser_lock;
            module_support_led <= module_unsupported ? led_red : led_green;
            module_unknown_led <= module_unknown ? led_orange : led_green;
        end
    end
endmodule : card_edge_status
`default_nettype wire

/* card_edge_pkg.sv */
// Constants, register map and state codes for the card-edge indicator block.
// Assumes a 20 MHz mclk and a classic Wishbone register bus.
package card_edge_pkg;

    localparam int clk_hz = 20_000_000;

    // Short debounce keeps a press cheap; raise it for very bouncy switches
    localparam int debounce_us = 100;
    localparam int flash_half_ms = 250;
    localparam int debounce_cycles = clk_hz / 1_000_000 * debounce_us;
    localparam int flash_half_cycles = clk_hz / 1000 * flash_half_ms;
    localparam int reboot_cycles = 16;

    // Register byte addresses
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [7:0] irq_status_addr = 8'h08;
    localparam logic [7:0] irq_mask_addr = 8'h0c;

    // Control register fields
    localparam int ctrl_running_bit = 0;
    localparam int ctrl_boot_wait_bit = 1;
    localparam int ctrl_config_err_bit = 2;
    localparam int ctrl_reboot_bit = 3;
    localparam logic [3:0] ctrl_reset = 4'h0;

    // Interrupt event positions
    localparam int ev_bypass = 0;
    localparam int ev_input = 1;
    localparam int ev_reset_button = 2;
    localparam int ev_module = 3;
    localparam int ev_width = 4;
    localparam logic [3:0] mask_reset = 4'h0;

    // Two-bit bicolour code: bit 0 green, bit 1 red, both orange
    typedef enum logic [1:0] {
        led_off = 2'b00,
        led_green = 2'b01,
        led_red = 2'b10,
        led_orange = 2'b11
    } led_color_t;

endpackage : card_edge_pkg

/* button_debounce.sv */
// Debounce of one pushbutton level with a one-cycle press pulse.
// Assumes the button input is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module button_debounce
    import card_edge_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic raw,
    output logic level,
    output logic press
);
    logic [19:0] count;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= 20'h00000;
            level <= 1'b0;
            press <= 1'b0;
        end
        else
        begin
            press <= 1'b0;
            if (raw == level)
                count <= 20'h00000;
            else if (count == 20'(debounce_cycles - 1))
            begin
                // Contact bounce is swallowed until the level holds
                count <= 20'h00000;
                level <= raw;
                press <= raw;
            end
            else
                count <= count + 20'h00001;
        end
    end
endmodule : button_debounce
`default_nettype wire

/* flash_divider.sv */
// Toggling flash phase from a free-running divider on mclk.
// Assumes nothing beyond the single mclk domain.
`timescale 1ns/1ps
`default_nettype none
module flash_divider
    import card_edge_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    output logic phase
);
    logic [23:0] count;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= 24'h000000;
            phase <= 1'b0;
        end
        else if (count == 24'(flash_half_cycles - 1))
        begin
            count <= 24'h000000;
            phase <= ~phase;
        end
        else
            count <= count + 24'h000001;
    end
endmodule : flash_divider
`default_nettype wire

/* card_edge_status_sva.sv */
// Port assertions for the card-edge indicator block.
// Assumes a bind to card_edge_status, one mclk domain.
`timescale 1ns/1ps
`default_nettype none
module card_edge_status_sva
    import card_edge_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic input_valid,
    input wire logic stream_ser_lock,
    input wire logic display_ser_lock,
    input wire logic module_unsupported,
    input wire logic module_unknown,
    input wire logic card_reboot,
    input wire logic bypass_relay,
    input wire logic [1:0] power_state_led,
    input wire logic bypass_red_led,
    input wire logic input_present_led,
    input wire logic stream_out_lock_led,
    input wire logic display_out_lock_led,
    input wire logic [1:0] module_support_led,
    input wire logic [1:0] bypass_mirror_led,
    input wire logic [1:0] no_input_led,
    input wire logic [1:0] module_unknown_led
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // First edge after release still shows reset values
    property p_in; $past(rstn) |-> input_present_led == $past(input_valid); endproperty
    a_in: assert property (p_in) else $error("input led lags");
    property p_noin; no_input_led == (input_present_led ? led_green : led_red); endproperty
    a_noin: assert property (p_noin) else $error("no-input mirror");
    property p_mir; bypass_mirror_led == (bypass_red_led ? led_red : led_green); endproperty
    a_mir: assert property (p_mir) else $error("bypass mirror");
    property p_bp; bypass_red_led == bypass_relay; endproperty
    a_bp: assert property (p_bp) else $error("bypass led against relay");
    property p_so;
        $past(rstn) |-> stream_out_lock_led == ($past(stream_ser_lock) && $past(input_valid));
    endproperty
    a_so: assert property (p_so) else $error("stream led");
    property p_do; $past(rstn) |-> display_out_lock_led == $past(display_ser_lock); endproperty
    a_do: assert property (p_do) else $error("display led");
    property p_ms;
        $past(rstn) |-> module_support_led == ($past(module_unsupported) ? led_red : led_green);
    endproperty
    a_ms: assert property (p_ms) else $error("module led");
    property p_mu;
        $past(rstn) |-> module_unknown_led == ($past(module_unknown) ? led_orange : led_green);
    endproperty
    a_mu: assert property (p_mu) else $error("unknown led");
    property p_or; power_state_led == led_orange |-> $past(input_valid); endproperty
    a_or: assert property (p_or) else $error("orange without input");
    property p_rb; $rose(card_reboot) |-> card_reboot [*8] ##1 card_reboot [*8] ##1 !card_reboot;
    endproperty
    a_rb: assert property (p_rb) else $error("reboot length");
endmodule : card_edge_status_sva
`default_nettype wire

/* card_edge_operator.sv */
// Operator at the card edge, pressing and releasing the two buttons.
// Assumes the bench calls push and that buttons read high while pressed.
`timescale 1ns/1ps
`default_nettype none
module card_edge_operator
    import card_edge_pkg::*;
(
    input wire logic mclk,
    output logic bypass_button,
    output logic reset_button
);
    // Released button reads low, no pull needed
    initial
    begin
        bypass_button = 1'h0;
        reset_button = 1'h0;
    end

    // Held and released past the debounce time so each push counts once
    task push(input logic which);
        @(posedge mclk);
        if (which)
            reset_button <= 1'h1;
        else
            bypass_button <= 1'h1;
        repeat (debounce_cycles + 4) @(posedge mclk);
        reset_button <= 1'h0;
        bypass_button <= 1'h0;
        repeat (debounce_cycles + 4) @(posedge mclk);
    endtask : push
endmodule : card_edge_operator
`default_nettype wire

/* card_edge_status_test.sv */
// Self-checking bench for card_edge_status.
// Assumes the operator model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module card_edge_status_test;
    import card_edge_pkg::*;
    logic mclk = '0, rstn = '0, cyc_i = '0, stb_i = '0, we_i = '0;
    logic [7:0] adr_i = '0;
    logic [3:0] sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd, r;
    logic ack_o, irq, bypass_button, reset_button, bypass_relay, card_reboot, pv;
    logic input_valid = '0, signal_fault = '0, stream_ser_lock = '0;
    logic display_ser_lock = '0, module_unsupported = '0, module_unknown = '0;
    logic [1:0] power_state_led, module_support_led, bypass_mirror_led;
    logic [1:0] no_input_led, module_unknown_led;
    logic bypass_red_led, input_present_led, stream_out_lock_led, display_out_lock_led;
    int num_errors = 0, compares = 0, seed = 32'h9a14, n, k;
    card_edge_status DUT (.*);
    card_edge_operator op (.mclk(mclk), .bypass_button(bypass_button), .reset_button(reset_button));
    task test_done;
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Entered at a rising edge; ends one idle cycle after ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge mclk); while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge mclk);
    endtask : wb
    // Not running or no input wins over a fault
    function logic [1:0] exp_pw(logic run, logic cfg, logic v, logic f);
        return (!v || !run) ? led_red : ((f || cfg) ? led_orange : led_green);
    endfunction : exp_pw
    initial
    begin
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge mclk);
        rstn <= 1'h1;
        @(posedge mclk);
        wb(1'h0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        wb(1'h1, status_addr, 32'hffffffff);
        wb(1'h0, status_addr, 32'h0);
        chk(rd, 32'h0);
        chk(power_state_led, led_red);
        wb(1'h1, irq_mask_addr, 32'h2);
        for (n = 0; n < 40; n++)
        begin
            r = $random(seed);
            wb(1'h1, ctrl_addr, {29'h0, r[7], 1'h0, r[6] | r[8]});
            pv = input_valid;
            {input_valid, signal_fault, stream_ser_lock} <= r[5:3];
            {display_ser_lock, module_unsupported, module_unknown} <= r[2:0];
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            chk(power_state_led, exp_pw(r[6] | r[8], r[7], r[5], r[4]));
            chk(input_present_led, r[5]);
            chk(no_input_led, r[5] ? led_green : led_red);
            chk(stream_out_lock_led, r[5] & r[3]);
            chk(display_out_lock_led, r[2]);
            chk(module_support_led, r[1] ? led_red : led_green);
            chk(module_unknown_led, r[0] ? led_orange : led_green);
            chk(bypass_red_led, 1'h0);
            chk(bypass_mirror_led, led_green);
            chk(irq, pv != r[5]);
            @(posedge mclk);
            wb(1'h0, irq_status_addr, 32'h0);
            chk(rd[1], pv != r[5]);
            @(negedge mclk);
            chk(irq, 1'h0);
            @(posedge mclk);
        end
        input_valid <= 1'h0;
        wb(1'h1, ctrl_addr, 32'h3);
        repeat (2) @(negedge mclk);
        chk(power_state_led[1], 1'h0);
        chk(power_state_led, led_off);
        @(posedge mclk);
        k = 0;
        fork
            wb(1'h1, ctrl_addr, 32'h8);
            repeat (30)
            begin
                @(negedge mclk);
                k += int'(card_reboot === 1'h1);
            end
        join
        chk(k, reboot_cycles);
        op.push(1'h0);
        @(negedge mclk);
        chk(bypass_relay, 1'h1);
        chk(bypass_red_led, 1'h1);
        chk(bypass_mirror_led, led_red);
        @(posedge mclk);
        wb(1'h0, status_addr, 32'h0);
        chk(rd[0], 1'h1);
        op.push(1'h0);
        @(negedge mclk);
        chk(bypass_relay, 1'h0);
        chk(bypass_red_led, 1'h0);
        chk(bypass_mirror_led, led_green);
        k = 0;
        fork
            op.push(1'h1);
            repeat (2 * debounce_cycles + 8)
            begin
                @(negedge mclk);
                k += int'(card_reboot === 1'h1);
            end
        join
        chk(k, reboot_cycles);
        test_done;
    end
endmodule : card_edge_status_test
bind card_edge_status card_edge_status_sva chk_i (.*);
`default_nettype wire
